/* File: rtl/eeprom_fe.sv */
/*
  two-wire slave front end of a small serial eeprom: condition detection,
  byte framing, acknowledge, write-protect, programming cycle timer,
  power-on and brown-out handling.
  assumes scl, sda, straps and supply monitor levels are asynchronous pins;
  the pad provides pull-downs on straps and wp, and resolves the open drain.
*/
`timescale 1ns/1ps
`default_nettype none
module eeprom_fe
    import eeprom_fe_pkg::*;
#(
    parameter int unsigned WR_CYC = T_WR_CYC
) (
    input  wire logic      ref_clk_in,
    input  wire logic      srst_in,
    input  wire logic      scl_in,
    input  wire logic      sda_in,
    output logic           sda_out,
    output logic           sda_oe_out,
    input  wire logic      addr_select_bit0_in,
    input  wire logic      addr_select_bit1_in,
    input  wire logic      addr_select_bit2_in,
    input  wire logic      wp_in,
    input  wire logic      por_ok_in,
    input  wire logic      bor_in,
    output rx_byte_t       rx_byte_out,
    output logic           prog_start_out,
    output logic           prog_busy_out,
    output logic           standby_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        fe_state_t   st;
        logic        scl_q;
        logic        sda_q;
        logic        por_q;
        logic        hold;
        logic [3:0]  cnt;
        logic        ack_ph;
        logic        acked;
        logic        armed;
        logic        special;
        logic [7:0]  sh;
        logic [WR_W-1:0] timer;
        logic        oe;
        logic        lvl;
        rx_byte_t    rx;
        logic        prog_start;
        logic        busy;
        logic        stby;
    } fe_t;

    fe_t      s_ff;
    fe_t      nxt_s;

    logic     scl_f;
    logic     sda_f;
    straps_t  strap;

    logic     scl_rise;
    logic     scl_fall;
    logic     start_c;
    logic     stop_c;
    logic     por_rise;
    logic     addr_match;
    logic     ack_now;

    // ------------------------------------------------------------
    // input conditioning
    // ------------------------------------------------------------
    input_filter #(
        .W   (1),
        .N   (FILT_CYC),
        .RST (BUS_RST[1])
    ) u_scl_filter (
        .clk_in    (ref_clk_in),
        .srst_in   (srst_in),
        .raw_in    (scl_in),
        .clean_out (scl_f)
    );

    input_filter #(
        .W   (1),
        .N   (FILT_CYC),
        .RST (BUS_RST[0])
    ) u_sda_filter (
        .clk_in    (ref_clk_in),
        .srst_in   (srst_in),
        .raw_in    (sda_in),
        .clean_out (sda_f)
    );

    // straps rely on pad pull-downs, so a floating pin arrives as zero
    input_filter #(
        .W   (6),
        .N   (STRAP_CYC),
        .RST (STRAP_RST)
    ) u_strap_sync (
        .clk_in    (ref_clk_in),
        .srst_in   (srst_in),
        .raw_in    ({wp_in, addr_select_bit2_in, addr_select_bit1_in,
                     addr_select_bit0_in, por_ok_in, bor_in}),
        .clean_out (strap)
    );

    // ------------------------------------------------------------
    // bus events
    // ------------------------------------------------------------
    always_comb begin
        scl_rise = scl_f & ~s_ff.scl_q;
        scl_fall = ~scl_f & s_ff.scl_q;
        start_c  = s_ff.scl_q & scl_f & s_ff.sda_q & ~sda_f;
        stop_c   = s_ff.scl_q & scl_f & ~s_ff.sda_q & sda_f;
        por_rise = strap.por_ok & ~s_ff.por_q;
    end

    // ------------------------------------------------------------
    // acknowledge decision
    // ------------------------------------------------------------
    always_comb begin
        addr_match = (s_ff.sh[TYPE_MSB:TYPE_LSB] == TYPE_ARRAY
                      || s_ff.sh[TYPE_MSB:TYPE_LSB] == TYPE_SPECIAL)
                     && s_ff.sh[SEL_MSB:SEL_LSB] == strap.sel;
        ack_now = 1'b0;
        unique case (s_ff.st)
            ST_ADDR: begin
                ack_now = addr_match;
            end
            ST_WORD: begin
                ack_now = 1'b1;
            end
            ST_DATA: begin
                ack_now = ~strap.wp;
            end
            default: begin
                ack_now = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_s            = s_ff;
        nxt_s.scl_q      = scl_f;
        nxt_s.sda_q      = sda_f;
        nxt_s.por_q      = strap.por_ok;
        nxt_s.lvl        = SDA_LOW;
        nxt_s.rx.valid   = 1'b0;
        nxt_s.prog_start = 1'b0;
        nxt_s.hold       = strap.bor | (s_ff.hold & ~por_rise);

        if (nxt_s.hold || !strap.por_ok) begin
            // bus is deaf while the supply is not trusted
            nxt_s.st     = ST_OFF;
            nxt_s.oe     = 1'b0;
            nxt_s.cnt    = '0;
            nxt_s.ack_ph = 1'b0;
            nxt_s.armed  = 1'b0;
            nxt_s.timer  = '0;
        end else begin
            unique case (s_ff.st)
                ST_OFF: begin
                    nxt_s.st = ST_STANDBY;
                end
                ST_PROG: begin
                    // self-timed: no start, stop or ack while it runs
                    nxt_s.oe = 1'b0;
                    if (s_ff.timer == WR_W'(WR_CYC - 1)) begin
                        nxt_s.st    = ST_STANDBY;
                        nxt_s.timer = '0;
                    end else begin
                        nxt_s.timer = s_ff.timer + WR_W'(1);
                    end
                end
                default: begin
                    if (start_c) begin
                        // also covers a repeated start and the recovery sequence
                        nxt_s.st     = ST_ADDR;
                        nxt_s.cnt    = '0;
                        nxt_s.ack_ph = 1'b0;
                        nxt_s.oe     = 1'b0;
                        nxt_s.armed  = 1'b0;
                    end else if (stop_c) begin
                        nxt_s.oe     = 1'b0;
                        nxt_s.cnt    = '0;
                        nxt_s.ack_ph = 1'b0;
                        nxt_s.armed  = 1'b0;
                        if (s_ff.armed) begin
                            nxt_s.st         = ST_PROG;
                            nxt_s.prog_start = 1'b1;
                            nxt_s.timer      = '0;
                        end else begin
                            nxt_s.st = ST_STANDBY;
                        end
                    end else if (s_ff.st == ST_ADDR || s_ff.st == ST_WORD
                                 || s_ff.st == ST_DATA) begin
                        if (scl_rise && s_ff.cnt < BITS_PER_BYTE) begin
                            nxt_s.sh  = {s_ff.sh[6:0], sda_f};
                            nxt_s.cnt = s_ff.cnt + 4'h1;
                        end
                        if (scl_fall) begin
                            if (s_ff.ack_ph) begin
                                // ninth clock over: release and move on
                                nxt_s.oe     = 1'b0;
                                nxt_s.ack_ph = 1'b0;
                                nxt_s.cnt    = '0;
                                unique case (s_ff.st)
                                    ST_ADDR: begin
                                        if (!s_ff.acked) begin
                                            nxt_s.st = ST_STANDBY;
                                        end else if (s_ff.sh[RW_BIT]) begin
                                            nxt_s.st = ST_IGNORE;
                                        end else begin
                                            nxt_s.st = ST_WORD;
                                        end
                                    end
                                    ST_WORD: begin
                                        nxt_s.st = ST_DATA;
                                    end
                                    default: begin
                                        nxt_s.st = ST_DATA;
                                    end
                                endcase
                                // only an acked data byte opens the tenth slot
                                nxt_s.armed = s_ff.acked && s_ff.st == ST_DATA;
                            end else if (s_ff.cnt == BITS_PER_BYTE) begin
                                nxt_s.ack_ph     = 1'b1;
                                nxt_s.acked      = ack_now;
                                nxt_s.oe         = ack_now;
                                nxt_s.rx.valid   = 1'b1;
                                nxt_s.rx.acked   = ack_now;
                                nxt_s.rx.data    = s_ff.sh;
                                if (s_ff.st == ST_ADDR) begin
                                    nxt_s.special = s_ff.sh[TYPE_MSB:TYPE_LSB] == TYPE_SPECIAL;
                                    nxt_s.rx.special = s_ff.sh[TYPE_MSB:TYPE_LSB] == TYPE_SPECIAL;
                                    nxt_s.rx.kind = BYTE_ADDR;
                                end else begin
                                    nxt_s.rx.special = s_ff.special;
                                    nxt_s.rx.kind = (s_ff.st == ST_WORD) ? BYTE_WORD : BYTE_DATA;
                                end
                            end else begin
                                // a falling clock here is inside the next byte, which
                                // holds only because the master leaves no idle clocks
                                nxt_s.armed = 1'b0;
                            end
                        end
                    end
                end
            endcase
        end

        nxt_s.busy = nxt_s.st == ST_PROG;
        nxt_s.stby = nxt_s.st == ST_STANDBY;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            s_ff            <= '0;
            s_ff.st         <= ST_OFF;
            s_ff.scl_q      <= BUS_RST[1];
            s_ff.sda_q      <= BUS_RST[0];
            s_ff.lvl        <= SDA_LOW;
            s_ff.rx.kind    <= BYTE_ADDR;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign sda_out        = s_ff.lvl;
    assign sda_oe_out     = s_ff.oe;
    assign rx_byte_out    = s_ff.rx;
    assign prog_start_out = s_ff.prog_start;
    assign prog_busy_out  = s_ff.busy;
    assign standby_out    = s_ff.stby;

endmodule
`default_nettype wire

/* File: rtl/eeprom_fe_pkg.sv */
/*
  constants, types and carriers for the two-wire eeprom slave front end.
  assumes a single 125 mhz core clock and a synchronous active-high reset.
*/
package eeprom_fe_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int FILT_NS       = 50;
    localparam int FILT_CYC      = (FILT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STRAP_CYC     = 1;
    localparam int T_WR_US       = 3000;
    localparam int T_WR_CYC      = int'((64'(T_WR_US) * 64'd1000000) / 64'(CLK_PERIOD_PS));
    localparam int WR_W          = 19;

    // ------------------------------------------------------------
    // byte framing and address byte fields
    // ------------------------------------------------------------
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] TYPE_ARRAY    = 4'hA;
    localparam logic [3:0] TYPE_SPECIAL  = 4'hB;
    localparam int         TYPE_MSB      = 7;
    localparam int         TYPE_LSB      = 4;
    localparam int         SEL_MSB       = 3;
    localparam int         SEL_LSB       = 1;
    localparam int         RW_BIT        = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [1:0] BUS_RST   = 2'h3;
    localparam logic [5:0] STRAP_RST = 6'h00;
    localparam logic       SDA_LOW   = 1'b0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF,
        ST_STANDBY,
        ST_ADDR,
        ST_WORD,
        ST_DATA,
        ST_IGNORE,
        ST_PROG
    } fe_state_t;

    typedef enum logic [1:0] {
        BYTE_ADDR,
        BYTE_WORD,
        BYTE_DATA
    } byte_kind_t;

    typedef struct packed {
        logic       valid;
        logic       acked;
        logic       special;
        byte_kind_t kind;
        logic [7:0] data;
    } rx_byte_t;

    typedef struct packed {
        logic       wp;
        logic [2:0] sel;
        logic       por_ok;
        logic       bor;
    } straps_t;

endpackage

/* File: rtl/input_filter.sv */
/*
  two-flop synchroniser followed by a persistence filter, per vector.
  assumes raw inputs are asynchronous to clk_in; bits share one counter,
  so instantiate one per independent line where glitch timing matters.
*/
`timescale 1ns/1ps
`default_nettype none
module input_filter #(
    parameter int               W   = 1,
    parameter int               N   = 1,
    parameter logic [W-1:0]     RST = '0
) (
    input  wire logic           clk_in,
    input  wire logic           srst_in,
    input  wire logic [W-1:0]   raw_in,
    output logic      [W-1:0]   clean_out
);
    localparam int CW = $clog2(N + 1);

    typedef struct packed {
        logic [W-1:0]  s1;
        logic [W-1:0]  s2;
        logic [W-1:0]  clean;
        logic [CW-1:0] cnt;
    } flt_t;

    flt_t s_ff;
    flt_t nxt_s;

    // ------------------------------------------------------------
    // filter
    // ------------------------------------------------------------
    always_comb begin
        nxt_s    = s_ff;
        nxt_s.s1 = raw_in;
        nxt_s.s2 = s_ff.s1;
        if (s_ff.s2 == s_ff.clean) begin
            nxt_s.cnt = '0;
        end else if (s_ff.cnt == CW'(N - 1)) begin
            nxt_s.clean = s_ff.s2;
            nxt_s.cnt   = '0;
        end else begin
            nxt_s.cnt = s_ff.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            s_ff <= '{s1: RST, s2: RST, clean: RST, cnt: '0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign clean_out = s_ff.clean;
endmodule
`default_nettype wire

/* File: test/eeprom_fe_checker.sv */
/*
  concurrent checks on the eeprom two-wire front end ports, bound to eeprom_fe.
  assumes straps and wp stay steady while a transfer runs.
*/
`timescale 1ns/1ps
`default_nettype none
module eeprom_fe_checker
    import eeprom_fe_pkg::*;
#(
    parameter int unsigned WR_CYC = 50
) (
    input wire logic     ref_clk_in,
    input wire logic     srst_in,
    input wire logic     scl_in,
    input wire logic     sda_out,
    input wire logic     sda_oe_out,
    input wire logic     addr_select_bit0_in,
    input wire logic     addr_select_bit1_in,
    input wire logic     addr_select_bit2_in,
    input wire logic     wp_in,
    input wire logic     por_ok_in,
    input wire rx_byte_t rx_byte_out,
    input wire logic     prog_start_out,
    input wire logic     prog_busy_out,
    input wire logic     standby_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);

    // ------------------------------------------------------------
    // helpers: busy length, last byte decision
    // ------------------------------------------------------------
    logic [31:0] busy_cnt_ff;
    logic        last_ok_ff;
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            busy_cnt_ff <= 32'h0;
            last_ok_ff  <= 1'b0;
        end else begin
            busy_cnt_ff <= prog_busy_out ? busy_cnt_ff + 32'h1 : 32'h0;
            if (rx_byte_out.valid)
                last_ok_ff <= rx_byte_out.kind == BYTE_DATA && rx_byte_out.acked;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_drain_only: assert property (sda_out == SDA_LOW)
        else $error("data drive level not low");
    a_edge_low: assert property ($changed(sda_oe_out) |-> !scl_in)
        else $error("data drive moved while clock high");
    a_ack_drive: assert property (rx_byte_out.valid |-> sda_oe_out == rx_byte_out.acked)
        else $error("ack drive disagrees with decision");
    a_addr_match: assert property (rx_byte_out.valid && rx_byte_out.kind == BYTE_ADDR |->
        rx_byte_out.acked == ((rx_byte_out.data[7:4] == TYPE_ARRAY || rx_byte_out.data[7:4] == TYPE_SPECIAL)
        && rx_byte_out.data[3:1] == {addr_select_bit2_in, addr_select_bit1_in, addr_select_bit0_in}))
        else $error("address decision wrong");
    a_word_ack: assert property (rx_byte_out.valid && rx_byte_out.kind == BYTE_WORD |-> rx_byte_out.acked)
        else $error("word byte not acked");
    a_wp_nack: assert property (rx_byte_out.valid && rx_byte_out.kind == BYTE_DATA && wp_in
        && $past(wp_in, 4) |-> !rx_byte_out.acked)
        else $error("protected data byte acked");
    a_prog_cause: assert property (prog_start_out |-> last_ok_ff)
        else $error("programming without acked data byte");
    a_prog_len: assert property ($fell(prog_busy_out) |-> busy_cnt_ff >= WR_CYC && busy_cnt_ff <= WR_CYC + 1)
        else $error("programming length wrong");
    a_prog_quiet: assert property (prog_busy_out |-> !sda_oe_out && !rx_byte_out.valid)
        else $error("bus answered during programming");
    a_prog_standby: assert property ($fell(prog_busy_out) |-> ##[0:1] standby_out)
        else $error("no standby after programming");
    a_standby_quiet: assert property (standby_out |-> !sda_oe_out)
        else $error("data driven in standby");
    a_supply_off: assert property (!por_ok_in [*6] |-> !sda_oe_out && !standby_out)
        else $error("active while supply reset held");

    c_data_ack: cover property (rx_byte_out.valid && rx_byte_out.acked && rx_byte_out.kind == BYTE_DATA);
    c_addr_nack: cover property (rx_byte_out.valid && !rx_byte_out.acked && rx_byte_out.kind == BYTE_ADDR);
    c_prog: cover property (prog_start_out);
endmodule

bind eeprom_fe eeprom_fe_checker #(.WR_CYC(WR_CYC)) u_chk (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .addr_select_bit0_in(addr_select_bit0_in),
    .addr_select_bit1_in(addr_select_bit1_in), .addr_select_bit2_in(addr_select_bit2_in),
    .wp_in(wp_in), .por_ok_in(por_ok_in), .rx_byte_out(rx_byte_out), .prog_start_out(prog_start_out),
    .prog_busy_out(prog_busy_out), .standby_out(standby_out)
);
`default_nettype wire

/* File: test/bus_master_model.sv */
/*
  behavioural two-wire bus master: drives the clock, pulls data low.
  assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output var logic  scl_out,
    output var logic  sda_oe_out
);
    // half bus period in core cycles; long enough for the input filter
    int half = 25;
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end

    task automatic pause(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // data moves mid low phase only; clock then stays high
    task automatic clk_bit(input logic b, output logic rd);
        scl_out <= 1'b0;
        pause(half / 2);
        sda_oe_out <= ~b;
        pause(half - half / 2);
        scl_out <= 1'b1;
        pause(half);
        rd = sda_in;
    endtask

    // start is (0,1), stop is (1,0)
    task automatic cond(input logic first, input logic last);
        scl_out <= 1'b0;
        pause(half / 2);
        sda_oe_out <= first;
        pause(half - half / 2);
        scl_out <= 1'b1;
        pause(half);
        sda_oe_out <= last;
        pause(half);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic d;
        for (int i = 7; i >= 0; i--) clk_bit(b[i], d);
        clk_bit(1'b1, d);
        ack = ~d;
    endtask

    // short low pulse on data while clock high
    task automatic glitch(input int n);
        sda_oe_out <= 1'b1;
        pause(n);
        sda_oe_out <= 1'b0;
        pause(half);
    endtask
endmodule
`default_nettype wire

/* File: test/tb.sv */
/*
  self-checking bench for eeprom_fe driven by a behavioural bus master.
  assumes a shortened programming time and a pulled-up data wire.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
    import eeprom_fe_pkg::*;
    localparam int unsigned WR = 200;
    logic       ref_clk_in = 1'b0;
    logic       srst_in    = 1'b1;
    logic       wp         = 1'b0;
    logic       por_ok     = 1'b1;
    logic       bor        = 1'b0;
    logic [2:0] sel        = 3'h0;
    logic       scl, m_oe, sda_oe, sda_drv, prog_start, prog_busy, standby, a;
    rx_byte_t   rx, last_rx;
    int         fail_count = 0;
    int         checks     = 0;
    int         seed       = 62;
    int         n_rx       = 0;
    int         n_prog     = 0;
    int         cyc        = 0;
    wire logic  sda = (sda_oe ? sda_drv : 1'b1) & ~m_oe;

    initial forever #4 ref_clk_in = ~ref_clk_in;

    eeprom_fe #(.WR_CYC(WR)) dut (
        .ref_clk_in(ref_clk_in), .srst_in(srst_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_drv),
        .sda_oe_out(sda_oe), .addr_select_bit0_in(sel[0]), .addr_select_bit1_in(sel[1]),
        .addr_select_bit2_in(sel[2]), .wp_in(wp), .por_ok_in(por_ok), .bor_in(bor), .rx_byte_out(rx),
        .prog_start_out(prog_start), .prog_busy_out(prog_busy), .standby_out(standby));
    bus_master_model m (.clk_in(ref_clk_in), .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));

    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (rx.valid === 1'b1) begin
            last_rx <= rx;
            n_rx <= n_rx + 1;
        end
        if (prog_start === 1'b1) n_prog <= n_prog + 1;
        if (cyc == 100000) begin
            fail_count++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    function automatic logic hit(input logic [7:0] b);
        return (b[7:4] == 4'hA || b[7:4] == 4'hB) && b[3:1] == sel;
    endfunction

    task automatic wait_idle();
        for (int k = 0; k < 400 && standby !== 1'b1; k++) @(posedge ref_clk_in);
        check(standby, 1'b1);
    endtask

    // one byte; when rcv the device must report it, else stay silent
    task automatic put(input logic [7:0] b, input byte_kind_t k, input logic exp, input logic rcv);
        int n0;
        n0 = n_rx;
        m.send_byte(b, a);
        check(a, exp);
        if (rcv) check({last_rx.kind, last_rx.data, last_rx.acked}, {k, b, exp});
        check(16'(n_rx - n0), 16'(rcv));
    endtask

    // start, address; on a hit word and n data bytes, stop right after the last ack; on a miss one more clock, then stop
    task automatic wr(input logic [7:0] ad, input int n);
        int p0;
        wait_idle();
        p0 = n_prog;
        m.cond(1'b0, 1'b1);
        put(ad, BYTE_ADDR, hit(ad), 1'b1);
        if (hit(ad)) begin
            check(last_rx.special, 16'(ad[7:4] == 4'hB));
            put(8'($random(seed)), BYTE_WORD, 1'b1, 1'b1);
            for (int i = 0; i < n; i++) put(8'($random(seed)), BYTE_DATA, ~wp, 1'b1);
        end else begin
            // the nack slot ends on the next clock fall; only then is the device back in standby
            m.clk_bit(1'b1, a);
            check(standby, 1'b1);
        end
        m.cond(1'b1, 1'b0);
        repeat (20) @(posedge ref_clk_in);
        check(16'(n_prog - p0), 16'(hit(ad) && n > 0 && !wp));
        check(prog_busy, 16'(hit(ad) && n > 0 && !wp));
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        wait_idle();
        for (int t = 0; t < 12; t++) begin
            sel <= 3'($random(seed));
            wp <= 1'($random(seed));
            m.half = 25 + 15 * (t % 2);
            @(posedge ref_clk_in);
            wr({4'hA + 4'(t % 3), (t % 4 == 3) ? ~sel : sel, 1'b0}, t % 4);
        end
        wp <= 1'b0;
        // start before programming ends is ignored
        wr({4'hA, sel, 1'b0}, 1);
        m.cond(1'b0, 1'b1);
        put({4'hA, sel, 1'b0}, BYTE_ADDR, 1'b0, 1'b0);
        m.cond(1'b1, 1'b0);
        // restart in mid byte begins a fresh address byte
        wait_idle();
        m.cond(1'b0, 1'b1);
        put({4'hA, sel, 1'b0}, BYTE_ADDR, 1'b1, 1'b1);
        repeat (4) m.clk_bit(1'b0, a);
        m.cond(1'b0, 1'b1);
        put({4'hB, sel, 1'b0}, BYTE_ADDR, 1'b1, 1'b1);
        m.cond(1'b1, 1'b0);
        // read direction: acked, then the device leaves the line released
        wait_idle();
        m.cond(1'b0, 1'b1);
        put({4'hA, sel, 1'b1}, BYTE_ADDR, 1'b1, 1'b1);
        m.clk_bit(1'b1, a);
        check(a, 1'b1);
        m.cond(1'b1, 1'b0);
        wait_idle();
        // recovery sequence: start, nine clocks, start, stop
        m.cond(1'b0, 1'b1);
        repeat (9) m.clk_bit(1'b1, a);
        m.cond(1'b0, 1'b1);
        m.cond(1'b1, 1'b0);
        wait_idle();
        // short spike on data is no start; bytes without start are ignored
        m.glitch(3);
        check(standby, 1'b1);
        put({4'hA, sel, 1'b0}, BYTE_ADDR, 1'b0, 1'b0);
        // brown-out holds the device off until power-on releases again
        bor <= 1'b1;
        m.pause(8);
        check(standby, 1'b0);
        m.cond(1'b0, 1'b1);
        put({4'hA, sel, 1'b0}, BYTE_ADDR, 1'b0, 1'b0);
        m.cond(1'b1, 1'b0);
        bor <= 1'b0;
        m.pause(8);
        check(standby, 1'b0);
        por_ok <= 1'b0;
        m.pause(8);
        por_ok <= 1'b1;
        wr({4'hA, sel, 1'b0}, 2);
        wait_idle();
        wrap_up();
    end
endmodule
`default_nettype wire
